// File: serial_cfg_pkg.sv
// Constants shared by the converter serial host interface.
`default_nettype none
package serial_cfg_pkg;
    // ------------------------------------------------------------------
    // Register word addresses and the key byte address
    // ------------------------------------------------------------------
    localparam logic [8:0] ADDR_IDENTITY = 9'h000;
    localparam logic [8:0] ADDR_RESET_POWER = 9'h004;
    localparam logic [8:0] ADDR_INPUT_CTL = 9'h008;
    localparam logic [8:0] ADDR_OUTPUT_CTL = 9'h00C;
    localparam logic [8:0] ADDR_WORD_CTL = 9'h010;
    localparam logic [8:0] ADDR_RANGE = 9'h014;
    localparam logic [8:0] ADDR_ALARM = 9'h020;
    localparam logic [8:0] ADDR_ALARM_HIGH = 9'h024;
    localparam logic [8:0] ADDR_ALARM_LOW = 9'h028;
    localparam logic [8:0] ADDR_KEY_BYTE = 9'h005;
    // ------------------------------------------------------------------
    // Field masks (writable bits of each register)
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_IDENTITY = 32'h000F_0000;
    localparam logic [31:0] MASK_RESET_POWER_BITS = 32'h0000_0037;
    localparam logic [31:0] MASK_RESET_POWER_KEY = 32'h0000_FF00;
    localparam logic [31:0] MASK_INPUT_CTL = 32'h0000_0003;
    localparam logic [31:0] MASK_OUTPUT_CTL = 32'h0000_1343;
    localparam logic [31:0] MASK_WORD_CTL = 32'h0000_7D0F;
    localparam logic [31:0] MASK_RANGE = 32'h0000_004F;
    localparam logic [31:0] MASK_ALARM = 32'h0000_FFFF;
    localparam logic [31:0] MASK_THRESHOLD = 32'hFFFF_FFFF;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h69;
    localparam int KEY_LSB = 8;
    localparam int DEVICE_ADDR_LSB = 16;
    localparam int OUTPUT_PIN_CFG_LSB = 8;
    localparam int SYNC_CLOCK_BIT = 6;
    localparam int DATA_VALUE_MSB = 2;
    // ------------------------------------------------------------------
    // Command opcodes (bits 31:27) and write byte select (bits 26:25)
    // ------------------------------------------------------------------
    localparam logic [4:0] OP_CLEAR_HALF = 5'h18;
    localparam logic [4:0] OP_READ_HALF = 5'h19;
    localparam logic [4:0] OP_READ_BYTE = 5'h09;
    localparam logic [4:0] OP_WRITE = 5'h1A;
    localparam logic [4:0] OP_SET_HALF = 5'h1B;
    localparam logic [1:0] WR_BOTH = 2'h0;
    localparam logic [1:0] WR_HIGH = 2'h1;
    localparam logic [1:0] WR_LOW = 2'h2;
    // ------------------------------------------------------------------
    // Protocol encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PROTO_IDLE_LOW_RISE = 2'h0;
    localparam logic [1:0] PROTO_IDLE_LOW_FALL = 2'h1;
    localparam logic [1:0] PROTO_IDLE_HIGH_FALL = 2'h2;
    localparam logic [1:0] PROTO_IDLE_HIGH_RISE = 2'h3;
    localparam logic [1:0] OUT_SOURCE_SYNC = 2'h3;
    localparam logic [1:0] OUT_INVALID = 2'h2;
    localparam logic [1:0] PIN_CFG_DUAL = 2'h3;
    localparam logic [7:0] DAISY_LOW_BYTE = 8'h00;
    localparam int FRAME_BITS = 32;
    localparam int COUNT_WIDTH = 7;
    // Divider of the internal source-sync bit clock.
    localparam int INT_CLOCK_DIV = 4;
    // ------------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FRAME_IDLE = 3'b001,
        FRAME_SHIFT = 3'b010,
        FRAME_DONE = 3'b100
    } frame_state_t;
endpackage : serial_cfg_pkg
`default_nettype wire

// File: pin_sync.sv
// Two-flop synchroniser with edge detection for the serial pins.
`default_nettype none
module pin_sync
    import serial_cfg_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] pin_in, // Asynchronous pin levels.
    output logic [WIDTH-1:0] level, // Synchronised levels.
    output logic [WIDTH-1:0] rise, // One-cycle pulse on a rising level.
    output logic [WIDTH-1:0] fall // One-cycle pulse on a falling level.
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    if (WIDTH < 1) begin : g_check
        $error("pin_sync WIDTH must be at least 1");
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule : pin_sync
`default_nettype wire

// File: adc_serial_protocol_config.sv
// Serial host interface of the converter: protocols, outputs and register map.
`default_nettype none
// Summary of operation
// - Reset selects idle-low, rising-capture protocol.
// - Input field picks one of four protocols.
// - Selected protocol governs both reads and writes.
// - Status pin held low during SPI frames, except in source-sync mode.
// - Output word shifted most significant first.
// - Long frame with low byte 00h daisy-chains.
// - Pin config 11b makes shared pin second lane.
// - Dual mode launches two bits per edge.
// - Dual mode halves clocks, same timing.
// - Source-sync mode drives clock on status pin.
// - Output clock from serial or internal clock.
// - Select bit 0 serial, 1 internal.
// - Output field 0x follows input, 11 source-sync.
// - Nine 32-bit registers, word addresses 00h-28h.
// - Device address bits 19-16, reset zero.
// - Power bits update only with key 69h.
// - Reserved fields ignore writes, read zero.
module adc_serial_protocol_config
    import serial_cfg_pkg::*;
(
    input wire logic ref_clk, // System clock, 250 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic convert_chip_select, // Frame select from host, active low frame.
    input wire logic serial_clock, // Serial clock from host.
    input wire logic serial_in, // Serial data from host.
    input wire logic [11:0] conversion_result, // Latest conversion result.
    input wire logic conversion_busy, // High while a conversion runs.
    input wire logic alarm_level, // Alarm state for the shared pin.
    output logic serial_out_lane0, // First serial data output.
    output logic serial_out_lane1, // Shared pin data level.
    output logic serial_out_lane1_en, // Shared pin output enable.
    output logic conversion_status_pin, // Busy status or output clock.
    output logic [5:0] power_control // Reset and power control bits.
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    pin_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin_in({serial_in, serial_clock, convert_chip_select}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    wire cs_fall = pin_fall[0];
    wire cs_rise = pin_rise[0];
    wire sclk_rise = pin_rise[1];
    wire sclk_fall = pin_fall[1];
    wire din = pin_level[2];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] device_identity_address;
    logic [31:0] reset_power_control;
    logic [31:0] serial_input_control;
    logic [31:0] serial_output_control;
    logic [31:0] output_word_control;
    logic [31:0] input_range_select;
    logic [31:0] alarm_output;
    logic [31:0] alarm_high_threshold;
    logic [31:0] alarm_low_threshold;

    wire [1:0] input_protocol_select = serial_input_control[1:0];
    wire [1:0] output_protocol_select = serial_output_control[1:0];
    wire [1:0] second_output_pin_config = serial_output_control[OUTPUT_PIN_CFG_LSB +: 2];
    wire sync_clock_source_select = serial_output_control[SYNC_CLOCK_BIT];
    wire source_synchronous_mode = (output_protocol_select == OUT_SOURCE_SYNC);
    wire dual_lane = (second_output_pin_config == PIN_CFG_DUAL);

    // ------------------------------------------------------------------
    // Capture and launch edges of the chosen protocol
    // ------------------------------------------------------------------
    // Rising capture for modes 0 and 3, falling for 1 and 2; launch is opposite.
    wire capture_on_rise = (input_protocol_select == PROTO_IDLE_LOW_RISE) ||
                           (input_protocol_select == PROTO_IDLE_HIGH_RISE);
    wire capture_edge = capture_on_rise ? sclk_rise : sclk_fall;
    wire sclk_launch = capture_on_rise ? sclk_fall : sclk_rise;

    // Internal bit clock for the source-synchronous internal clock option.
    logic [3:0] div_count;
    logic int_tick;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= '0;
            int_tick <= 1'b0;
        end else begin
            int_tick <= (div_count == 4'(INT_CLOCK_DIV - 1));
            div_count <= (div_count == 4'(INT_CLOCK_DIV - 1)) ? '0 : div_count + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    frame_state_t state;
    frame_state_t next_state;
    logic [COUNT_WIDTH-1:0] clk_count;
    logic [31:0] in_shift;
    logic [31:0] out_shift;
    logic launched_any;
    logic src_clk_level;
    logic [31:0] next_word;

    wire in_frame = (state == FRAME_SHIFT);
    // Source-sync internal clock: one launch per two ticks, clock toggles each tick.
    wire src_int = source_synchronous_mode && sync_clock_source_select;
    wire int_launch = src_int && int_tick && !src_clk_level;
    wire launch = in_frame && (src_int ? int_launch : (sclk_launch && launched_any));
    wire write_ok = (clk_count >= COUNT_WIDTH'(FRAME_BITS));
    wire daisy = (serial_output_control[7:0] == DAISY_LOW_BYTE);

    always_comb begin
        next_state = state;
        case (state)
            FRAME_IDLE: if (cs_fall) next_state = FRAME_SHIFT;
            FRAME_SHIFT: if (cs_rise) next_state = FRAME_DONE;
            FRAME_DONE: next_state = FRAME_IDLE;
            default: next_state = FRAME_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= FRAME_IDLE;
            clk_count <= '0;
            in_shift <= '0;
            launched_any <= 1'b0;
        end else begin
            state <= next_state;
            if (cs_fall) begin
                clk_count <= '0;
                launched_any <= 1'b0;
            end else if (in_frame && capture_edge) begin
                in_shift <= {in_shift[30:0], din};
                if (clk_count != '1) clk_count <= clk_count + 1'b1;
                launched_any <= 1'b1;
            end
        end
    end

    // Output shift: loaded at frame start, MSB first, one or two bits per launch.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_shift <= '0;
        end else if (cs_fall) begin
            out_shift <= next_word;
        end else if (launch) begin
            if (dual_lane) out_shift <= {out_shift[29:0], 2'b00};
            else if (daisy) out_shift <= {out_shift[30:0], in_shift[0]};
            else out_shift <= {out_shift[30:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_clk_level <= 1'b0;
        end else if (!in_frame || !source_synchronous_mode) begin
            src_clk_level <= 1'b0;
        end else if (src_int ? int_tick : (sclk_rise || sclk_fall)) begin
            src_clk_level <= ~src_clk_level;
        end
    end

    // ------------------------------------------------------------------
    // Command decode at frame end
    // ------------------------------------------------------------------
    wire [4:0] cmd_op = in_shift[31:27];
    wire [1:0] cmd_sel = in_shift[26:25];
    wire [8:0] cmd_addr = in_shift[24:16];
    wire [15:0] cmd_data = in_shift[15:0];
    wire [8:0] word_addr = {cmd_addr[8:2], 2'b00};
    wire upper_half = cmd_addr[1];
    wire cmd_exec = (state == FRAME_DONE) && write_ok;

    logic [4:0] read_op;
    logic [8:0] read_addr;

    function automatic logic [31:0] reg_read(input logic [8:0] a);
        case (a)
            ADDR_IDENTITY: reg_read = device_identity_address;
            ADDR_RESET_POWER: reg_read = reset_power_control;
            ADDR_INPUT_CTL: reg_read = serial_input_control;
            ADDR_OUTPUT_CTL: reg_read = serial_output_control;
            ADDR_WORD_CTL: reg_read = output_word_control;
            ADDR_RANGE: reg_read = input_range_select;
            ADDR_ALARM: reg_read = alarm_output;
            ADDR_ALARM_HIGH: reg_read = alarm_high_threshold;
            ADDR_ALARM_LOW: reg_read = alarm_low_threshold;
            default: reg_read = RESET_WORD;
        endcase
    endfunction : reg_read

    // Half-word modification applied by write, set and clear commands.
    function automatic logic [31:0] modify(input logic [31:0] old, input logic [31:0] mask);
        logic [15:0] half;
        logic [15:0] result;
        half = upper_half ? old[31:16] : old[15:0];
        result = half;
        case (cmd_op)
            OP_WRITE: begin
                if (cmd_sel == WR_BOTH) result = cmd_data;
                else if (cmd_sel == WR_HIGH) result = {cmd_data[15:8], half[7:0]};
                else if (cmd_sel == WR_LOW) result = {half[15:8], cmd_data[7:0]};
            end
            OP_SET_HALF: result = half | cmd_data;
            OP_CLEAR_HALF: result = half & ~cmd_data;
            default: result = half;
        endcase
        modify = upper_half ? {result, old[15:0]} : {old[31:16], result};
        modify = (modify & mask) | (old & ~mask);
    endfunction : modify

    // A byte write with the key to byte 05h arms the protected bits.
    wire key_write = cmd_exec && (cmd_op == OP_WRITE) && (cmd_sel == WR_HIGH) &&
                     (cmd_addr == ADDR_KEY_BYTE) && (cmd_data[15:8] == UNLOCK_KEY_VALUE);
    wire key_open = (reset_power_control[KEY_LSB +: 8] == UNLOCK_KEY_VALUE);
    wire [31:0] rp_mask = key_open ? (MASK_RESET_POWER_BITS | MASK_RESET_POWER_KEY)
                                   : MASK_RESET_POWER_KEY;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            device_identity_address <= RESET_WORD;
            reset_power_control <= RESET_WORD;
            serial_input_control <= RESET_WORD;
            serial_output_control <= RESET_WORD;
            output_word_control <= RESET_WORD;
            input_range_select <= RESET_WORD;
            alarm_output <= RESET_WORD;
            alarm_high_threshold <= RESET_WORD;
            alarm_low_threshold <= RESET_WORD;
        end else if (cmd_exec) begin
            case (word_addr)
                ADDR_IDENTITY: device_identity_address <= modify(device_identity_address, MASK_IDENTITY);
                ADDR_RESET_POWER: reset_power_control <= key_write ?
                    modify(reset_power_control, MASK_RESET_POWER_KEY) :
                    modify(reset_power_control, rp_mask);
                ADDR_INPUT_CTL: serial_input_control <= modify(serial_input_control, MASK_INPUT_CTL);
                ADDR_OUTPUT_CTL: serial_output_control <= modify(serial_output_control, MASK_OUTPUT_CTL);
                ADDR_WORD_CTL: output_word_control <= modify(output_word_control, MASK_WORD_CTL);
                ADDR_RANGE: input_range_select <= modify(input_range_select, MASK_RANGE);
                ADDR_ALARM: alarm_output <= modify(alarm_output, MASK_ALARM);
                ADDR_ALARM_HIGH: alarm_high_threshold <= modify(alarm_high_threshold, MASK_THRESHOLD);
                ADDR_ALARM_LOW: alarm_low_threshold <= modify(alarm_low_threshold, MASK_THRESHOLD);
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            read_op <= '0;
            read_addr <= '0;
        end else if (state == FRAME_DONE) begin
            read_op <= write_ok ? cmd_op : 5'h00;
            read_addr <= write_ok ? cmd_addr : 9'h000;
        end
    end

    // ------------------------------------------------------------------
    // Output word for the next frame
    // ------------------------------------------------------------------
    wire [31:0] read_word = reg_read({read_addr[8:2], 2'b00});
    wire [15:0] read_half = read_addr[1] ? read_word[31:16] : read_word[15:0];
    wire [7:0] read_byte = read_addr[0] ? read_half[15:8] : read_half[7:0];
    wire [2:0] data_value = output_word_control[DATA_VALUE_MSB:0];

    always_comb begin
        next_word = {conversion_result, 20'h00000};
        if (data_value[2]) begin
            case (data_value[1:0])
                2'h0: next_word = 32'h0000_0000;
                2'h1: next_word = 32'hFFFF_FFFF;
                2'h2: next_word = 32'hAAAA_AAAA;
                default: next_word = 32'hCCCC_CCCC;
            endcase
        end else if (read_op == OP_READ_HALF) begin
            next_word = {read_half, 16'h0000};
        end else if (read_op == OP_READ_BYTE) begin
            next_word = {read_byte, 24'h000000};
        end
    end

    // ------------------------------------------------------------------
    // Registered pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out_lane0 <= 1'b0;
            serial_out_lane1 <= 1'b0;
            serial_out_lane1_en <= 1'b0;
            conversion_status_pin <= 1'b0;
            power_control <= '0;
        end else begin
            serial_out_lane0 <= out_shift[31];
            serial_out_lane1 <= dual_lane ? out_shift[30] :
                                (second_output_pin_config == 2'h1) ? alarm_level :
                                serial_output_control[12];
            serial_out_lane1_en <= (second_output_pin_config != 2'h0);
            if (in_frame && source_synchronous_mode) conversion_status_pin <= src_clk_level;
            else if (in_frame) conversion_status_pin <= 1'b0;
            else conversion_status_pin <= !conversion_busy;
            power_control <= reset_power_control[5:0];
        end
    end
endmodule : adc_serial_protocol_config
`default_nettype wire

// File: adc_serial_protocol_config_assertions.sv
// Port-level checker for the converter serial host interface.
`default_nettype none
module adc_serial_protocol_config_assertions (
    input wire logic ref_clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic convert_chip_select, // Frame select.
    input wire logic serial_clock, // Serial clock.
    input wire logic conversion_busy, // Busy.
    input wire logic serial_out_lane0, // Lane 0.
    input wire logic serial_out_lane1, // Lane 1.
    input wire logic serial_out_lane1_en, // Lane 1 enable.
    input wire logic conversion_status_pin, // Status pin.
    input wire logic [5:0] power_control // Power bits.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] age;
    logic [3:0] low_cnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // Cycles since a host pin edge and since the status pin was high.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            age <= 4'hF;
            low_cnt <= 4'h0;
        end else begin
            age <= ($changed(serial_clock) || $changed(convert_chip_select)) ? 4'h0 :
                (age == 4'hF) ? age : age + 4'h1;
            low_cnt <= conversion_status_pin ? 4'h0 : (low_cnt == 4'hF) ? low_cnt : low_cnt + 4'h1;
        end
    end
    AST_POWER_AFTER_FRAME: assert property (
        !$stable(power_control) |-> convert_chip_select && $past(convert_chip_select, 2))
        else $error("power bits changed inside a frame");
    AST_LANE1_EN_AFTER_FRAME: assert property (
        !$stable(serial_out_lane1_en) |-> convert_chip_select && $past(convert_chip_select, 2))
        else $error("lane 1 enable changed inside a frame");
    AST_STATUS_LOW_AT_OPEN: assert property (
        $fell(convert_chip_select) |-> ##[1:8] !conversion_status_pin)
        else $error("status pin not low after frame open");
    AST_RESET_OUTPUTS: assert property (
        $rose(reset_n) |-> power_control == 6'h00 && !serial_out_lane1_en)
        else $error("outputs not cleared by reset");
    AST_POWER_RESERVED: assert property (power_control[3] == 1'b0)
        else $error("reserved power bit set");
    AST_LANE0_FOLLOWS_CLOCK: assert property (
        $changed(serial_out_lane0) && !convert_chip_select && low_cnt == 4'hF |-> age <= 4'h8)
        else $error("lane 0 moved without a serial clock edge");
    AST_LANE1_FOLLOWS_CLOCK: assert property (
        $changed(serial_out_lane1) && serial_out_lane1_en && !convert_chip_select
        && low_cnt == 4'hF |-> age <= 4'h8)
        else $error("lane 1 moved without a serial clock edge");
    AST_STATUS_IDLE_HIGH: assert property (
        (convert_chip_select && !conversion_busy) [*8] |-> conversion_status_pin)
        else $error("status pin not high while idle");
endmodule : adc_serial_protocol_config_assertions
bind adc_serial_protocol_config adc_serial_protocol_config_assertions sva_i (.ref_clk, .reset_n,
    .convert_chip_select, .serial_clock, .conversion_busy, .serial_out_lane0, .serial_out_lane1,
    .serial_out_lane1_en, .conversion_status_pin, .power_control);
`default_nettype wire

// File: serial_host_model.sv
// Host controller model that frames commands on the serial pins.
`default_nettype none
module serial_host_model (
    output logic convert_chip_select, // Frame select.
    output logic serial_clock, // Serial clock.
    output logic serial_in, // Command data.
    input wire logic serial_out_lane0, // Lane 0.
    input wire logic serial_out_lane1, // Lane 1.
    input wire logic conversion_status_pin // Status pin.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] rx0;
    logic [63:0] rx1;
    int n_status = 0;
    initial begin
        convert_chip_select = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    always @(posedge conversion_status_pin) n_status = n_status + (convert_chip_select ? 0 : 1);
    // Sends the top n bits of tx; the clock idles between frames.
    task automatic frame(input logic [63:0] tx, input int n, input logic [1:0] mode);
        serial_clock = mode[1];
        convert_chip_select = 1'b0;
        n_status = 0;
        #24;
        for (int i = 0; i < n; i++) begin
            if (mode[0]) serial_clock = ~serial_clock;
            serial_in = tx[63-i];
            #16 serial_clock = ~serial_clock;
            #6 rx0[63-i] = serial_out_lane0;
            rx1[63-i] = serial_out_lane1;
            #10;
            if (!mode[0]) serial_clock = ~serial_clock;
        end
        #16 convert_chip_select = 1'b1;
        #40;
    endtask : frame
endmodule : serial_host_model
`default_nettype wire

// File: adc_serial_protocol_config_tb.sv
// Self-checking testbench for the converter serial host interface.
`default_nettype none
module adc_serial_protocol_config_tb import serial_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, reset_n = 1'b0, conversion_busy = 1'b0, alarm_level = 1'b0;
    logic [11:0] conversion_result = 12'hA5C;
    logic convert_chip_select, serial_clock, serial_in, serial_out_lane0, serial_out_lane1;
    logic serial_out_lane1_en, conversion_status_pin;
    logic [5:0] power_control;
    logic [31:0] word;
    int n_mismatch = 0;
    int n_compared = 0;
    always #2 ref_clk = ~ref_clk;
    adc_serial_protocol_config adc_serial_protocol_config_i (.ref_clk, .reset_n,
        .convert_chip_select, .serial_clock, .serial_in, .conversion_result, .conversion_busy,
        .alarm_level, .serial_out_lane0, .serial_out_lane1, .serial_out_lane1_en,
        .conversion_status_pin, .power_control);
    serial_host_model serial_host_model_i (.convert_chip_select, .serial_clock, .serial_in,
        .serial_out_lane0, .serial_out_lane1, .conversion_status_pin);
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic xfer(input logic [31:0] c, input logic [1:0] m);
        serial_host_model_i.frame({c, 32'h0000_0000}, 32, m);
        word = serial_host_model_i.rx0[63:32];
    endtask : xfer
    task automatic wr(input logic [1:0] sel, input logic [8:0] a, input logic [15:0] d,
        input logic [1:0] m);
        xfer({OP_WRITE, sel, a, d}, m);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [15:0] exp, input logic [1:0] m);
        xfer({OP_READ_HALF, 2'h0, a, 16'h0000}, m);
        xfer(32'h0000_0000, m);
        check("read half word", {exp, 16'h0000}, word);
    endtask : rd
    task automatic t_reset();
        check("power after reset", 32'h0000_0000, {26'h0, power_control});
        rd(9'h008, 16'h0000, 2'h0);
        wr(WR_BOTH, 9'h002, 16'hFFFF, 2'h0);
        rd(9'h002, 16'h000F, 2'h0);
        rd(9'h018, 16'h0000, 2'h0);
        $display("done reset");
    endtask : t_reset
    task automatic t_key();
        wr(WR_BOTH, 9'h004, 16'h003F, 2'h0);
        check("locked power", 32'h0000_0000, {26'h0, power_control});
        wr(WR_HIGH, ADDR_KEY_BYTE, 16'h6900, 2'h0);
        wr(WR_BOTH, 9'h004, 16'h693F, 2'h0);
        check("unlocked power", 32'h0000_0037, {26'h0, power_control});
        rd(9'h004, 16'h6937, 2'h0);
        serial_host_model_i.frame({OP_WRITE, WR_BOTH, 9'h004, 16'h6900, 32'h0}, 16, 2'h0);
        check("short frame word", 32'h0000_0A5C, {20'h0, serial_host_model_i.rx0[63:52]});
        check("short frame write", 32'h0000_0037, {26'h0, power_control});
        $display("done key");
    endtask : t_key
    task automatic t_modes();
        for (int m = 1; m < 4; m++) begin
            wr(WR_BOTH, ADDR_INPUT_CTL, 16'(m), 2'h0);
            xfer(32'h0000_0000, 2'(m));
            check("word in mode", {conversion_result, 20'h0}, word);
            check("status in frame", 32'h0, 32'(serial_host_model_i.n_status));
            rd(ADDR_INPUT_CTL, 16'(m), 2'(m));
            wr(WR_BOTH, ADDR_INPUT_CTL, 16'h0000, 2'(m));
        end
        $display("done modes");
    endtask : t_modes
    task automatic t_outputs();
        wr(WR_BOTH, ADDR_OUTPUT_CTL, 16'h0300, 2'h0);
        serial_host_model_i.frame(64'h0, 16, 2'h0);
        for (int k = 0; k < 16; k++) begin
            word[31-2*k] = serial_host_model_i.rx0[63-k];
            word[30-2*k] = serial_host_model_i.rx1[63-k];
        end
        check("dual word", {conversion_result, 20'h0}, word);
        check("lane 1 enable", 32'h1, {31'h0, serial_out_lane1_en});
        for (int s = 0; s < 2; s++) begin
            wr(WR_BOTH, ADDR_OUTPUT_CTL, s ? 16'h0043 : 16'h0003, 2'h0);
            serial_host_model_i.frame(64'h0, s ? 0 : 32, 2'h0);
            check("sync clock", 32'h1, 32'(serial_host_model_i.n_status > 0));
        end
        wr(WR_BOTH, ADDR_OUTPUT_CTL, 16'h0000, 2'h0);
        serial_host_model_i.frame({32'h1234_5678, 32'h0}, 64, 2'h0);
        check("chained word", 32'h1234_5678, serial_host_model_i.rx0[31:0]);
        $display("done outputs");
    endtask : t_outputs
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        t_reset();
        t_key();
        t_modes();
        t_outputs();
        results();
    end
endmodule : adc_serial_protocol_config_tb
`default_nettype wire
